// ==== wkt_consts.svh ====
`ifndef WKT_CONSTS_SVH
`define WKT_CONSTS_SVH
// register indices; byte address is four times the index
`define WKT_IDX_T3_RLD_HI 6'h1f
`define WKT_IDX_T3_RLD_LO 6'h20
`define WKT_IDX_T3_CNT_HI 6'h21
`define WKT_IDX_T3_CNT_LO 6'h22
`define WKT_IDX_CTRL 6'h23
`define WKT_IDX_WK_RLD_HI 6'h24
`define WKT_IDX_WK_RLD_LO 6'h25
`define WKT_IDX_WK_CNT_HI 6'h26
`define WKT_IDX_WK_CNT_LO 6'h27
// control register fields
`define WKT_CTRL_RUNNING 7
`define WKT_CTRL_STROBE 6
`define WKT_CTRL_TRIM 5
`define WKT_CTRL_SENSE 4
`define WKT_CTRL_RELOAD 3
`define WKT_CTRL_WAKE 2
`define WKT_CTRL_CLK_HI 1
`define WKT_CTRL_CLK_LO 0
// reset values
`define WKT_RST_BYTE 8'h00
`define WKT_RST_CTRL 6'h00
`define WKT_RST_CNT 16'h0000
// prescaler terminal counts (divide minus one)
`define WKT_DIV_1 5'h00
`define WKT_DIV_8 5'h07
`define WKT_DIV_16 5'h0f
`define WKT_DIV_32 5'h1f
`endif

// ==== wkt_pkg.sv ====
package wkt_pkg;
	// timer three phase
	typedef enum logic [1:0] {
		WKT_T3_IDLE,
		WKT_T3_COUNT,
		WKT_T3_SENSE
	} wkt_t3_phase_t;
	typedef logic [15:0] wkt_count_t;
endpackage

// ==== wkt_timer.sv ====
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "wkt_consts.svh"
module wkt_timer #(
	parameter int ADDR_W = 8
)(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	input wire logic i_slow_oscillator,
	input wire logic i_t3_start,
	input wire logic i_t3_tick,
	input wire logic i_card_found,
	input wire logic i_card_absent,
	input wire logic i_irq_clear,
	output logic o_wake_timer_irq_flag,
	output logic o_wake_underflow,
	output logic o_trim_start,
	output logic o_card_sense_start,
	output logic o_wakeup,
	output logic o_card_irq,
	output logic o_stay_active,
	output logic o_power_down,
	output logic o_rf_field_on,
	output logic o_t3_underflow
);
	// elaboration check: the register map needs eight address bits
	if (ADDR_W < 8)
	begin
		$error("ADDR_W must be at least 8");
	end

	// prescaler terminal count for the selected division
	function automatic logic [4:0] div_limit(input logic [1:0] sel);
		logic [4:0] r;
		r = `WKT_DIV_1;
		unique case (sel)
			2'h0: r = `WKT_DIV_1;
			2'h1: r = `WKT_DIV_8;
			2'h2: r = `WKT_DIV_16;
			2'h3: r = `WKT_DIV_32;
		endcase
		return r;
	endfunction

	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [7:0] t3_rld_hi_q;
	logic [7:0] t3_rld_lo_q;
	logic [7:0] wk_rld_hi_q;
	logic [7:0] wk_rld_lo_q;
	logic [5:0] ctrl_q;
	logic running_q;
	wkt_pkg::wkt_count_t wk_cnt_q;
	wkt_pkg::wkt_count_t t3_cnt_q;
	wkt_pkg::wkt_t3_phase_t t3_phase_q;
	logic [4:0] div_q;
	logic osc_s1_q;
	logic osc_s2_q;
	logic osc_s3_q;
	logic irq_q;
	logic wk_uf_q;
	logic trim_q;
	logic sense_q;
	logic wake_q;
	logic card_irq_q;
	logic stay_q;
	logic pdown_q;
	logic rf_q;
	logic t3_uf_q;

	// bus decode
	wire logic [5:0] idx = i_paddr[7:2];
	wire logic access = i_psel & i_penable & ~pready_q;
	wire logic wr_fire = i_psel & i_penable & pready_q & i_pwrite & mapped;
	wire logic [7:0] wb = i_pwdata[7:0];
	wire logic wr_t3_hi = wr_fire & (idx == `WKT_IDX_T3_RLD_HI);
	wire logic wr_t3_lo = wr_fire & (idx == `WKT_IDX_T3_RLD_LO);
	wire logic wr_ctrl = wr_fire & (idx == `WKT_IDX_CTRL);
	wire logic wr_wk_hi = wr_fire & (idx == `WKT_IDX_WK_RLD_HI);
	wire logic wr_wk_lo = wr_fire & (idx == `WKT_IDX_WK_RLD_LO);
	wire logic mapped;
	assign mapped = (idx >= `WKT_IDX_T3_RLD_HI)
		&& (idx <= `WKT_IDX_WK_CNT_LO)
		&& ((i_paddr >> 8) == '0)
		&& (i_paddr[1:0] == 2'h0);

	// read mux; strobe bit always reads zero
	logic [7:0] rbyte;
	always_comb
	begin
		rbyte = 8'h00;
		unique case (idx)
			`WKT_IDX_T3_RLD_HI: rbyte = t3_rld_hi_q;
			`WKT_IDX_T3_RLD_LO: rbyte = t3_rld_lo_q;
			`WKT_IDX_T3_CNT_HI: rbyte = t3_cnt_q[15:8];
			`WKT_IDX_T3_CNT_LO: rbyte = t3_cnt_q[7:0];
			`WKT_IDX_CTRL: rbyte = {running_q, 1'b0, ctrl_q};
			`WKT_IDX_WK_RLD_HI: rbyte = wk_rld_hi_q;
			`WKT_IDX_WK_RLD_LO: rbyte = wk_rld_lo_q;
			`WKT_IDX_WK_CNT_HI: rbyte = wk_cnt_q[15:8];
			`WKT_IDX_WK_CNT_LO: rbyte = wk_cnt_q[7:0];
			default: rbyte = 8'h00;
		endcase
	end

	// run control requests from a strobed control write
	wire logic go = wr_ctrl & wb[`WKT_CTRL_STROBE] & wb[`WKT_CTRL_RUNNING];
	wire logic halt = wr_ctrl & wb[`WKT_CTRL_STROBE] & ~wb[`WKT_CTRL_RUNNING];

	// slow oscillator rising edge, read only after the second stage
	wire logic osc_edge = osc_s2_q & ~osc_s3_q;
	wire logic [4:0] lim = div_limit(ctrl_q[`WKT_CTRL_CLK_HI:`WKT_CTRL_CLK_LO]);
	wire logic tick = running_q & osc_edge & (div_q >= lim);
	wire logic wk_uf = tick & (wk_cnt_q == '0);
	wire logic keep_on = ctrl_q[`WKT_CTRL_RELOAD] | ctrl_q[`WKT_CTRL_SENSE];
	wire logic sense_go = wk_uf & ctrl_q[`WKT_CTRL_SENSE];
	wire logic t3_uf = (t3_phase_q != wkt_pkg::WKT_T3_IDLE) & i_t3_tick
		& (t3_cnt_q == '0);
	wire logic [15:0] wk_rld = {wk_rld_hi_q, wk_rld_lo_q};
	wire logic [15:0] t3_rld = {t3_rld_hi_q, t3_rld_lo_q};

	// bus answer: one wait cycle, registered data and error
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			pready_q <= access;
			if (access)
			begin
				prdata_q <= {24'h00_0000, rbyte};
				pslverr_q <= ~mapped;
			end
		end
	end

	// software registers, loaded only by mapped writes
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			t3_rld_hi_q <= `WKT_RST_BYTE;
			t3_rld_lo_q <= `WKT_RST_BYTE;
			wk_rld_hi_q <= `WKT_RST_BYTE;
			wk_rld_lo_q <= `WKT_RST_BYTE;
			ctrl_q <= `WKT_RST_CTRL;
		end
		else if (i_clk_en)
		begin
			if (wr_t3_hi)
				t3_rld_hi_q <= wb;
			if (wr_t3_lo)
				t3_rld_lo_q <= wb;
			if (wr_wk_hi)
				wk_rld_hi_q <= wb;
			if (wr_wk_lo)
				wk_rld_lo_q <= wb;
			if (wr_ctrl)
				ctrl_q <= wb[5:0];
		end
	end

	// oscillator synchroniser and edge stage
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			osc_s1_q <= i_slow_oscillator;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
		end
	end

	// wake timer: prescaler, run state and count
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			running_q <= 1'b0;
			wk_cnt_q <= `WKT_RST_CNT;
			div_q <= 5'h00;
		end
		else if (i_clk_en)
		begin
			if (go)
			begin
				running_q <= 1'b1;
				wk_cnt_q <= wk_rld;
				div_q <= 5'h00;
			end
			else if (halt)
				running_q <= 1'b0;
			else if (running_q && osc_edge)
			begin
				div_q <= tick ? 5'h00 : div_q + 5'h01;
				if (wk_uf)
				begin
					wk_cnt_q <= keep_on ? wk_rld : wk_cnt_q;
					running_q <= keep_on;
				end
				else if (tick)
					wk_cnt_q <= wk_cnt_q - 16'h0001;
			end
		end
	end

	// timer three: started by its event or by card sensing
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			t3_phase_q <= wkt_pkg::WKT_T3_IDLE;
			t3_cnt_q <= `WKT_RST_CNT;
		end
		else if (i_clk_en)
		begin
			if (sense_go || i_t3_start)
			begin
				t3_cnt_q <= t3_rld;
				t3_phase_q <= sense_go ? wkt_pkg::WKT_T3_SENSE
					: wkt_pkg::WKT_T3_COUNT;
			end
			else if (t3_uf)
				t3_phase_q <= wkt_pkg::WKT_T3_IDLE;
			else if (t3_phase_q != wkt_pkg::WKT_T3_IDLE && i_t3_tick)
				t3_cnt_q <= t3_cnt_q - 16'h0001;
		end
	end

	// event outputs and sticky interrupt flag
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			irq_q <= 1'b0;
			wk_uf_q <= 1'b0;
			trim_q <= 1'b0;
			sense_q <= 1'b0;
			wake_q <= 1'b0;
			card_irq_q <= 1'b0;
			stay_q <= 1'b0;
			pdown_q <= 1'b0;
			rf_q <= 1'b0;
			t3_uf_q <= 1'b0;
		end
		else if (i_clk_en)
		begin
			irq_q <= wk_uf | (irq_q & ~i_irq_clear);
			wk_uf_q <= wk_uf;
			trim_q <= wk_uf & ctrl_q[`WKT_CTRL_TRIM];
			sense_q <= sense_go;
			wake_q <= wk_uf & ctrl_q[`WKT_CTRL_WAKE];
			card_irq_q <= i_card_found;
			if (i_card_found)
				stay_q <= ~ctrl_q[`WKT_CTRL_WAKE];
			else if (sense_go)
				stay_q <= 1'b0;
			pdown_q <= i_card_absent & ctrl_q[`WKT_CTRL_WAKE];
			rf_q <= (t3_phase_q == wkt_pkg::WKT_T3_SENSE) & ~t3_uf;
			t3_uf_q <= t3_uf;
		end
	end

	assign o_pready = pready_q;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q;
	assign o_wake_timer_irq_flag = irq_q;
	assign o_wake_underflow = wk_uf_q;
	assign o_trim_start = trim_q;
	assign o_card_sense_start = sense_q;
	assign o_wakeup = wake_q;
	assign o_card_irq = card_irq_q;
	assign o_stay_active = stay_q;
	assign o_power_down = pdown_q;
	assign o_rf_field_on = rf_q;
	assign o_t3_underflow = t3_uf_q;
endmodule

// ==== wkt_timer_checker.sv ====
`timescale 1ns/1ns
module wkt_timer_checker (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic i_card_found,
	input wire logic i_card_absent,
	input wire logic o_wake_timer_irq_flag,
	input wire logic o_wake_underflow,
	input wire logic o_trim_start,
	input wire logic o_card_sense_start,
	input wire logic o_wakeup,
	input wire logic o_card_irq,
	input wire logic o_power_down,
	input wire logic o_rf_field_on,
	input wire logic o_t3_underflow
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// first access cycle of a bus transfer
	sequence acc_s;
		i_psel && i_penable && !o_pready && i_clk_en;
	endsequence
	bus_answer_a: assert property (acc_s |=> o_pready)
		else $error("bus answer missing");
	trim_start_a: assert property (o_trim_start |-> o_wake_underflow)
		else $error("trim start without underflow");
	sense_start_a: assert property (o_card_sense_start |-> o_wake_underflow)
		else $error("sense start without underflow");
	wake_pulse_a: assert property (o_wakeup |-> o_wake_underflow)
		else $error("wakeup without underflow");
	irq_flag_a: assert property (o_wake_underflow |-> o_wake_timer_irq_flag)
		else $error("flag not set");
	card_irq_a: assert property (i_card_found && i_clk_en |=> o_card_irq)
		else $error("card irq missing");
	power_down_a: assert property (o_power_down |-> $past(i_card_absent))
		else $error("power down without cause");
	uf_single_a: assert property (o_wake_underflow |=> !o_wake_underflow)
		else $error("underflow pulse too long");
	rf_off_a: assert property (o_t3_underflow |=> !o_rf_field_on)
		else $error("field stays on");
endmodule
bind wkt_timer wkt_timer_checker u_chk (.i_sys_clk, .i_reset_n, .i_clk_en,
	.i_psel, .i_penable, .o_pready, .i_card_found, .i_card_absent,
	.o_wake_timer_irq_flag, .o_wake_underflow, .o_trim_start,
	.o_card_sense_start, .o_wakeup, .o_card_irq, .o_power_down,
	.o_rf_field_on, .o_t3_underflow);

// ==== wkt_timer_test.sv ====
`timescale 1ns/1ns
`include "wkt_consts.svh"
module wkt_timer_test;
	logic i_sys_clk = 0, i_reset_n = 0, i_clk_en = 1, i_psel = 0;
	logic i_penable = 0, i_pwrite = 0, i_slow_oscillator = 0;
	logic i_t3_start = 0, i_t3_tick = 0, i_card_found = 0;
	logic i_card_absent = 0, i_irq_clear = 0, se;
	logic [7:0] i_paddr = 8'h00, rd;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic o_pready, o_pslverr, o_wake_timer_irq_flag, o_wake_underflow;
	logic o_trim_start, o_card_sense_start, o_wakeup, o_card_irq;
	logic o_stay_active, o_power_down, o_rf_field_on, o_t3_underflow;
	int err_count = 0, tests_run = 0, nu, nt, nc, nw, np, nr, nk;
	int dv[4] = '{1, 8, 16, 32};
	wkt_timer DUT (.i_sys_clk, .i_reset_n, .i_clk_en, .i_psel, .i_penable,
		.i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
		.i_slow_oscillator, .i_t3_start, .i_t3_tick, .i_card_found,
		.i_card_absent, .i_irq_clear, .o_wake_timer_irq_flag,
		.o_wake_underflow, .o_trim_start, .o_card_sense_start, .o_wakeup,
		.o_card_irq, .o_stay_active, .o_power_down, .o_rf_field_on,
		.o_t3_underflow);
	initial forever #5 i_sys_clk = ~i_sys_clk;
	// tally of event pulses
	always @(posedge i_sys_clk)
	begin
		nu += o_wake_underflow;
		nt += o_trim_start;
		nc += o_card_sense_start;
		nw += o_wakeup;
		np += o_power_down;
		nr += o_t3_underflow;
		nk += o_card_irq;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one bus transfer; only the watchdog ends a hang
	task apb(input logic w, input logic [5:0] x, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= {x, 2'b00};
		i_pwdata <= {24'h0, d};
		@(posedge i_sys_clk);
		i_penable <= 1;
		do
		begin
			@(posedge i_sys_clk);
		end
		while (o_pready !== 1'b1);
		rd = o_prdata[7:0];
		se = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task wr(input logic [5:0] x, input logic [7:0] d);
		apb(1'b1, x, d);
	endtask
	task rc(input logic [5:0] x, input logic [7:0] e);
		apb(1'b0, x, 8'h00);
		chk(rd, e);
	endtask
	// rising edges of the slow oscillator, wide enough for the synchroniser
	task edg(input int k);
		repeat (k)
		begin
			@(posedge i_sys_clk) i_slow_oscillator <= 1;
			repeat (3) @(posedge i_sys_clk);
			i_slow_oscillator <= 0;
			repeat (3) @(posedge i_sys_clk);
		end
	endtask
	task pz(input int w);
		@(posedge i_sys_clk);
		case (w)
			0: i_t3_tick <= 1;
			1: i_t3_start <= 1;
			2: i_card_found <= 1;
			3: i_card_absent <= 1;
			default: i_irq_clear <= 1;
		endcase
		@(posedge i_sys_clk);
		{i_t3_tick, i_t3_start, i_card_found, i_card_absent, i_irq_clear} <= 5'h0;
		repeat (2) @(posedge i_sys_clk);
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#400000;
		err_count++;
		close_out;
	end
	initial
	begin
		repeat (5) @(posedge i_sys_clk);
		i_reset_n <= 1;
		rc(`WKT_IDX_CTRL, 8'h00);
		wr(`WKT_IDX_T3_RLD_HI, 8'h5a);
		wr(`WKT_IDX_T3_RLD_LO, 8'ha5);
		wr(`WKT_IDX_WK_RLD_HI, 8'h3c);
		wr(`WKT_IDX_WK_RLD_LO, 8'h03);
		rc(`WKT_IDX_T3_RLD_HI, 8'h5a);
		rc(`WKT_IDX_T3_RLD_LO, 8'ha5);
		rc(`WKT_IDX_WK_RLD_HI, 8'h3c);
		rc(`WKT_IDX_WK_RLD_LO, 8'h03);
		wr(`WKT_IDX_WK_CNT_LO, 8'hff);
		rc(`WKT_IDX_WK_CNT_LO, 8'h00);
		apb(1'b0, 6'h28, 8'h00);
		chk({7'h0, se}, 8'h01);
		$display("registers done");
		wr(`WKT_IDX_WK_RLD_HI, 8'h00);
		wr(`WKT_IDX_CTRL, 8'h80);
		rc(`WKT_IDX_CTRL, 8'h00);
		wr(`WKT_IDX_CTRL, 8'hc0);
		rc(`WKT_IDX_CTRL, 8'h80);
		rc(`WKT_IDX_WK_CNT_LO, 8'h03);
		edg(1);
		rc(`WKT_IDX_WK_CNT_LO, 8'h02);
		wr(`WKT_IDX_CTRL, 8'h40);
		edg(2);
		rc(`WKT_IDX_WK_CNT_LO, 8'h02);
		nu = 0;
		wr(`WKT_IDX_CTRL, 8'hc0);
		edg(3);
		rc(`WKT_IDX_CTRL, 8'h80);
		edg(1);
		rc(`WKT_IDX_CTRL, 8'h00);
		rc(`WKT_IDX_WK_CNT_HI, 8'h00);
		chk(8'(nu), 8'h01);
		chk({7'h0, o_wake_timer_irq_flag}, 8'h01);
		pz(4);
		chk({7'h0, o_wake_timer_irq_flag}, 8'h00);
		$display("run control done");
		for (int s = 0; s < 4; s++)
		begin
			wr(`WKT_IDX_CTRL, 8'hc0 + 8'(s));
			edg(dv[s] - 1);
			rc(`WKT_IDX_WK_CNT_LO, 8'h03);
			edg(1);
			rc(`WKT_IDX_WK_CNT_LO, 8'h02);
			wr(`WKT_IDX_CTRL, 8'h40);
		end
		$display("prescaler done");
		wr(`WKT_IDX_WK_RLD_LO, 8'h00);
		{nu, nt, nc, nw} = 0;
		wr(`WKT_IDX_CTRL, 8'hec);
		edg(3);
		chk(8'(nu), 8'h03);
		chk(8'(nt), 8'h03);
		chk(8'(nw), 8'h03);
		chk(8'(nc), 8'h00);
		rc(`WKT_IDX_CTRL, 8'hac);
		wr(`WKT_IDX_CTRL, 8'h40);
		$display("auto reload done");
		wr(`WKT_IDX_T3_RLD_HI, 8'h00);
		wr(`WKT_IDX_T3_RLD_LO, 8'h02);
		wr(`WKT_IDX_CTRL, 8'hd0);
		edg(1);
		chk(8'(nc), 8'h01);
		rc(`WKT_IDX_CTRL, 8'h90);
		chk({7'h0, o_rf_field_on}, 8'h01);
		wr(`WKT_IDX_T3_RLD_LO, 8'h07);
		rc(`WKT_IDX_T3_CNT_LO, 8'h02);
		repeat (3) pz(0);
		chk(8'(nr), 8'h01);
		chk({7'h0, o_rf_field_on}, 8'h00);
		rc(`WKT_IDX_T3_CNT_HI, 8'h00);
		pz(1);
		rc(`WKT_IDX_T3_CNT_LO, 8'h07);
		pz(2);
		chk({7'h0, o_stay_active}, 8'h01);
		chk(8'(nk), 8'h01);
		np = 0;
		pz(3);
		chk(8'(np), 8'h00);
		wr(`WKT_IDX_CTRL, 8'h14);
		pz(3);
		chk(8'(np), 8'h01);
		$display("card detect done");
		// reset in mid-run clears registers and levels
		i_reset_n <= 0;
		repeat (2) @(posedge i_sys_clk);
		i_reset_n <= 1;
		rc(`WKT_IDX_CTRL, 8'h00);
		rc(`WKT_IDX_T3_RLD_LO, 8'h00);
		chk({7'h0, o_stay_active}, 8'h00);
		$display("reset done");
		close_out;
	end
endmodule
